// ---- dv/core_mode_props.sv ----
/*
  Assertion checker for the core mode and result register bank.
  Assumes it is bound to core_mode_regs and sees only its ports.
*/
`timescale 1ns/100ps
module core_mode_props #(
  parameter int IRQ_N = 8
) (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire core_mode_pkg::mode_ctrl_t  mode_ctrl,
  input wire logic                       cache_fill_req,
  input wire logic                       cache_fill_ok,
  input wire logic                       loop_early_req,
  input wire logic                       loop_late_mode,
  input wire logic                       sys_in_service,
  input wire logic                       higher_in_service,
  input wire logic                       sys_may_latch,
  input wire logic [IRQ_N-1:0]           irq_mask
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // Bus answer
  // ==========================================================================
  // Every access phase is answered one cycle later, errors only with it.
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered in one cycle");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("slave error without ready");

  // ==========================================================================
  // Mode outputs
  // ==========================================================================
  // Two settled cycles of a mode bit fix the registered outputs.
  cache_freeze_a: assert property (
    mode_ctrl.cache_freeze && $past(mode_ctrl.cache_freeze) |-> !cache_fill_ok)
    else $error("fill accepted while frozen");
  cache_disable_a: assert property (
    mode_ctrl.cache_disable && $past(mode_ctrl.cache_disable) |-> !cache_fill_ok)
    else $error("fill accepted while disabled");
  fill_open_a: assert property (
    $past(cache_fill_req) && mode_ctrl[4:3] == 2'h0 && $past(mode_ctrl[4:3]) == 2'h0
    |-> cache_fill_ok) else $error("fill refused while cache open");
  slow_loop_a: assert property (
    mode_ctrl.slow_loop && $past(mode_ctrl.slow_loop) |-> loop_late_mode)
    else $error("slow loop did not force late mode");
  early_loop_a: assert property (
    !mode_ctrl.slow_loop && !$past(mode_ctrl.slow_loop) && $past(loop_early_req)
    |-> !loop_late_mode) else $error("early loop request ignored");
  self_latch_a: assert property (
    mode_ctrl.self_nest && $past(mode_ctrl.self_nest) |-> sys_may_latch)
    else $error("system interrupt blocked with self nesting");
  nest_block_a: assert property (
    !mode_ctrl.self_nest && !$past(mode_ctrl.self_nest) && $past(sys_in_service)
    |-> !sys_may_latch) else $error("system interrupt relatched without self nesting");
  preempt_mask_a: assert property (
    $past(higher_in_service) |-> irq_mask == IRQ_N'(1))
    else $error("system interrupt not masked on preemption");
  idle_mask_a: assert property (
    !$past(sys_in_service) && !$past(higher_in_service) |-> irq_mask == '0)
    else $error("mask set with nothing in service");
endmodule // core_mode_props

bind core_mode_regs core_mode_props #(.IRQ_N(IRQ_N)) props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .mode_ctrl(mode_ctrl),
  .cache_fill_req(cache_fill_req), .cache_fill_ok(cache_fill_ok),
  .loop_early_req(loop_early_req), .loop_late_mode(loop_late_mode),
  .sys_in_service(sys_in_service), .higher_in_service(higher_in_service),
  .sys_may_latch(sys_may_latch), .irq_mask(irq_mask)
);

// ---- dv/test_core_mode_and_mac_result_regs.sv ----
/*
  Self-checking bench for the core mode and result register bank.
  Assumes core_mode_pkg and the bound checker are compiled first.
*/
`timescale 1ns/100ps
module test_core_mode_and_mac_result_regs;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q;} row_t;
  logic                         pclk, presetn, psel, penable, pwrite, err;
  logic                         pready, pslverr, stack_push, cache_fill_req;
  logic                         loop_early_req, sys_in_service, higher_in_service;
  logic                         cache_fill_ok, loop_late_mode, sys_may_latch;
  logic [7:0]                   paddr, irq_mask;
  logic [31:0]                  pwdata, prdata, rd, t0;
  core_mode_pkg::mac_write_t    mac_write;
  core_mode_pkg::access_event_t access_event;
  core_mode_pkg::mode_ctrl_t    mode_ctrl;
  int                           mismatches, n_checks, i;
  logic [31:0] m2[5] = '{32'h0, 32'h0008_0000, 32'h10, 32'h80, 32'h20};
  row_t rows[10] = '{'{8'h00, 32'hffff_ffff, 32'h0000_fcff}, '{8'h00, 32'h0, 32'h0},
    '{8'h04, 32'hffff_ffff, 32'h0038_00b1}, '{8'h04, 32'h0, 32'h0},
    '{8'h10, 32'h1111_1111, 32'h1111_1111}, '{8'h14, 32'h2222_2222, 32'h2222_2222},
    '{8'h18, 32'h3333_3333, 32'h3333_3333}, '{8'h1c, 32'h4444_4444, 32'h4444_4444},
    '{8'h20, 32'hffff_5555, 32'h5555}, '{8'h24, 32'hffff_6666, 32'h6666}};

  core_mode_regs #(.IRQ_N(8)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mac_write(mac_write), .access_event(access_event),
    .stack_push(stack_push), .cache_fill_req(cache_fill_req),
    .loop_early_req(loop_early_req), .sys_in_service(sys_in_service),
    .higher_in_service(higher_in_service), .mode_ctrl(mode_ctrl),
    .cache_fill_ok(cache_fill_ok), .loop_late_mode(loop_late_mode),
    .sys_may_latch(sys_may_latch), .irq_mask(irq_mask)
  );

  // Free-running 10 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input string nm, input logic [79:0] seen, input logic [79:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One APB transfer, entered just after a rising edge; holds until pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] q);
    apb(1'b0, a, 32'h0);
    check(nm, rd, q);
  endtask

  // Reads the three slices of one result and compares the whole value.
  task automatic res_chk(input string nm, input logic [7:0] a, input logic [79:0] v);
    logic [31:0] lo, mi;
    apb(1'b0, a, 32'h0);
    lo = rd;
    apb(1'b0, a + 8'h08, 32'h0);
    mi = rd;
    apb(1'b0, a + 8'h10, 32'h0);
    check(nm, {rd[15:0], mi, lo}, v);
  endtask

  task automatic mac(input logic bg, input logic [79:0] v);
    mac_write <= '{1'b1, bg, v};
    @(posedge pclk);
    mac_write <= '0;
    @(posedge pclk);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {presetn, psel, penable, pwrite, stack_push, cache_fill_req} = '0;
    {loop_early_req, sys_in_service, higher_in_service} = '0;
    {paddr, pwdata, mac_write, access_event, mismatches, n_checks} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Ordinary register cases from the table.
    foreach (rows[r]) begin
      wr(rows[r].a, rows[r].d);
      rd_chk("table_read", rows[r].a, rows[r].q);
    end
    rd_chk("bg_low_kept", 8'h10, 32'h1111_1111);
    rd_chk("fg_low_kept", 8'h14, 32'h2222_2222);
    apb(1'b0, 8'h30, 32'h0);
    check("unmapped", {err, rd}, {1'b1, 32'h0});
    // Result writes land in the chosen register, then swap.
    mac(1'b1, 80'h1234_89ab_cdef_0123_4567);
    mac(1'b0, 80'h5678_fedc_ba98_7654_3210);
    res_chk("mac_bg", 8'h10, 80'h1234_89ab_cdef_0123_4567);
    res_chk("mac_fg", 8'h14, 80'h5678_fedc_ba98_7654_3210);
    wr(8'h08, 32'h4);
    res_chk("swap_fg", 8'h14, 80'h1234_89ab_cdef_0123_4567);
    res_chk("swap_bg", 8'h10, 80'h5678_fedc_ba98_7654_3210);
    // Stack push mirrors the first mode register.
    wr(8'h08, 32'h0000_d8a9);
    stack_push <= 1'b1;
    @(posedge pclk);
    stack_push <= 1'b0;
    @(posedge pclk);
    rd_chk("stack_push", 8'h00, 32'h0000_d8a9);
    // Self nesting with the system interrupt in service.
    wr(8'h04, 32'h1);
    sys_in_service <= 1'b1;
    repeat (3) @(posedge pclk);
    check("nest_mask", {sys_may_latch, irq_mask}, 9'h1fe);
    rd_chk("mask_read", 8'h2c, 32'hfe);
    higher_in_service <= 1'b1;
    repeat (2) @(posedge pclk);
    check("preempt_mask", irq_mask, 8'h01);
    higher_in_service <= 1'b0;
    wr(8'h04, 32'h0);
    repeat (2) @(posedge pclk);
    check("no_relatch", sys_may_latch, 1'b0);
    sys_in_service <= 1'b0;
    // Sticky flags follow their enables.
    for (i = 0; i < 2; i++) begin
      wr(8'h04, i ? 32'h0030_0000 : 32'h0);
      access_event <= '1;
      @(posedge pclk);
      access_event <= '0;
      @(posedge pclk);
      rd_chk("sticky", 8'h0c, i ? 32'h3 : 32'h0);
    end
    wr(8'h0c, 32'h3);
    rd_chk("sticky_clear", 8'h0c, 32'h0);
    // Cache, loop and mode outputs for each control bit except self nesting.
    cache_fill_req <= 1'b1;
    loop_early_req <= 1'b1;
    for (i = 0; i < 5; i++) begin
      wr(8'h04, m2[i]);
      repeat (2) @(posedge pclk);
      check("fill_ok", cache_fill_ok, !m2[i][19] && !m2[i][4]);
      check("late_loop", loop_late_mode, m2[i][7]);
      check("mode_ctrl", mode_ctrl, {m2[i][19], m2[i][4], m2[i][7], m2[i][5], m2[i][0]});
    end
    cache_fill_req <= 1'b0;
    loop_early_req <= 1'b0;
    // Timer counts only while enabled.
    for (i = 0; i < 2; i++) begin
      wr(8'h04, i ? 32'h0 : 32'h20);
      apb(1'b0, 8'h28, 32'h0);
      t0 = rd;
      apb(1'b0, 8'h28, 32'h0);
      check("timer_moves", rd != t0, i == 0);
    end
    // Reset in mid-run clears the registers.
    wr(8'h04, 32'hffff_ffff);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("mode_ctrl_rst", mode_ctrl, 5'h0);
    rd_chk("mode2_rst", 8'h04, 32'h0);
    rd_chk("bg_low_rst", 8'h10, 32'h0);
    wrap_up();
  end
endmodule // test_core_mode_and_mac_result_regs

// ---- logic/core_mode_regs.sv ----
/*
  Holds the core mode registers, the stack top mirror and the first
  element multiplier result registers behind an APB slave.
  Assumes one clock pclk at 10 MHz and the core's events as pulses.
*/
`timescale 1ns/100ps
module core_mode_regs #(
  parameter int IRQ_N = core_mode_pkg::SYS_IRQ_W
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire core_mode_pkg::mac_write_t   mac_write,
  input  wire core_mode_pkg::access_event_t access_event,
  input  wire logic                        stack_push,
  input  wire logic                        cache_fill_req,
  input  wire logic                        loop_early_req,
  input  wire logic                        sys_in_service,
  input  wire logic                        higher_in_service,
  output core_mode_pkg::mode_ctrl_t        mode_ctrl,
  output logic                             cache_fill_ok,
  output logic                             loop_late_mode,
  output logic                             sys_may_latch,
  output logic      [IRQ_N-1:0]            irq_mask
);
  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [31:0]              mode_first;
    logic [31:0]              stack_top;
    logic [31:0]              mode_second;
    logic [1:0]               sticky;
    logic [79:0]              result_fg;
    logic [79:0]              result_bg;
    logic [31:0]              timer;
    logic [31:0]              rdata;
    logic                     ready;
    logic                     slverr;
    core_mode_pkg::mode_ctrl_t ctrl;
    logic                     fill_ok;
    logic                     late_mode;
    logic                     may_latch;
    logic [IRQ_N-1:0]         mask;
  } state_t;

  state_t st;
  state_t next_st;

  logic [2:0]       fg_sel;
  logic [2:0]       bg_sel;
  logic [79:0]      fg_merged;
  logic [79:0]      bg_merged;
  logic             comb_may_latch;
  logic [IRQ_N-1:0] comb_mask;
  logic             wr_phase;
  logic             access;

  // Strobe-masked write of a 32-bit word.
  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Picks which slice of a result a given address selects.
  function automatic logic [2:0] slice_of(input logic [7:0] a,
                                          input logic [7:0] low,
                                          input logic [7:0] mid,
                                          input logic [7:0] high);
    logic [2:0] r;
    r = 3'h0;
    if (a == low) begin
      r = 3'h1;
    end else if (a == mid) begin
      r = 3'h2;
    end else if (a == high) begin
      r = 3'h4;
    end
    return r;
  endfunction

  // ==========================================================================
  // Slice merges and interrupt masking
  // ==========================================================================
  // First access cycle decodes; a write lands at the edge that sees pready high.
  assign access   = psel && penable && !st.ready;
  assign wr_phase = psel && penable && st.ready && pwrite;
  assign fg_sel   = wr_phase ? slice_of(paddr, core_mode_pkg::OFF_RESULT_FG_LOW,
                    core_mode_pkg::OFF_RESULT_FG_MID,
                    core_mode_pkg::OFF_RESULT_FG_HIGH) : 3'h0;
  assign bg_sel   = wr_phase ? slice_of(paddr, core_mode_pkg::OFF_RESULT_BG_LOW,
                    core_mode_pkg::OFF_RESULT_BG_MID,
                    core_mode_pkg::OFF_RESULT_BG_HIGH) : 3'h0;

  result_slice_merge u_fg_merge (
    .current   (st.result_fg),
    .slice_sel (fg_sel),
    .wdata     (pwdata),
    .merged    (fg_merged)
  );

  result_slice_merge u_bg_merge (
    .current   (st.result_bg),
    .slice_sel (bg_sel),
    .wdata     (pwdata),
    .merged    (bg_merged)
  );

  system_irq_mask #(.N(IRQ_N)) u_irq_mask (
    .self_nest         (st.mode_second[core_mode_pkg::BIT_SELF_NEST_EN]),
    .global_en         (st.mode_first[core_mode_pkg::BIT_GLOBAL_IRQ_EN]),
    .nesting           (st.mode_first[core_mode_pkg::BIT_IRQ_NESTING]),
    .sys_in_service    (sys_in_service),
    .higher_in_service (higher_in_service),
    .sys_may_latch     (comb_may_latch),
    .mask              (comb_mask)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Register writes, hardware events, result updates and read mux.
  always_comb begin
    logic        swap_now;
    logic [79:0] held;
    next_st  = st;
    swap_now = 1'b0;
    held     = '0;
    next_st.ready  = access;
    next_st.slverr = 1'b0;

    // APB register writes.
    if (wr_phase) begin
      if (paddr == core_mode_pkg::OFF_MODE_STACK_TOP) begin
        next_st.stack_top = apply_strb(st.stack_top, pwdata, pstrb)
                            & core_mode_pkg::STACK_TOP_MASK;
      end else if (paddr == core_mode_pkg::OFF_MODE_SECOND) begin
        next_st.mode_second = apply_strb(st.mode_second, pwdata, pstrb)
                              & core_mode_pkg::MODE_SECOND_MASK;
      end else if (paddr == core_mode_pkg::OFF_MODE_FIRST) begin
        next_st.mode_first = apply_strb(st.mode_first, pwdata, pstrb);
        swap_now = pwdata[core_mode_pkg::BIT_RESULT_SWAP] && pstrb[0]
                   && !st.mode_first[core_mode_pkg::BIT_RESULT_SWAP];
      end else if (paddr == core_mode_pkg::OFF_STICKY) begin
        next_st.sticky = st.sticky & ~pwdata[1:0]; // Write one to clear.
      end else if (paddr == core_mode_pkg::OFF_TIMER_COUNT) begin
        next_st.timer = pwdata;
      end
    end

    // Status stack push copies the low mode bits into the top entry.
    if (stack_push) begin
      next_st.stack_top = st.mode_first & core_mode_pkg::STACK_TOP_MASK;
    end

    // Sticky flags: a hardware set wins over a software clear.
    if (access_event.unaligned_long
        && st.mode_second[core_mode_pkg::BIT_UNALIGNED_EN]) begin
      next_st.sticky[core_mode_pkg::BIT_UNALIGNED_STICKY] = 1'b1;
    end
    if (access_event.illegal_reg
        && st.mode_second[core_mode_pkg::BIT_ILLEGAL_EN]) begin
      next_st.sticky[core_mode_pkg::BIT_ILLEGAL_STICKY] = 1'b1;
    end

    // Core timer counts only while its run bit is set.
    if (st.mode_second[core_mode_pkg::BIT_TIMER_RUN] && !(wr_phase
        && paddr == core_mode_pkg::OFF_TIMER_COUNT)) begin
      next_st.timer = st.timer + 32'h1;
    end

    // Result registers: slice writes, swap, then MAC write to the one to_background selects.
    next_st.result_fg = fg_merged;
    next_st.result_bg = bg_merged;
    if (swap_now) begin
      held = next_st.result_fg;
      next_st.result_fg = next_st.result_bg;
      next_st.result_bg = held;
    end
    if (mac_write.valid) begin
      if (mac_write.to_background) begin
        next_st.result_bg = mac_write.value;
      end else begin
        next_st.result_fg = mac_write.value;
      end
    end

    // Read data mux; its address check also flags unmapped writes with pready.
    next_st.rdata = 32'h0;
    if (access) begin
      if (paddr == core_mode_pkg::OFF_MODE_STACK_TOP) begin
        next_st.rdata = st.stack_top;
      end else if (paddr == core_mode_pkg::OFF_MODE_SECOND) begin
        next_st.rdata = st.mode_second;
      end else if (paddr == core_mode_pkg::OFF_MODE_FIRST) begin
        next_st.rdata = st.mode_first;
      end else if (paddr == core_mode_pkg::OFF_STICKY) begin
        next_st.rdata = {30'h0, st.sticky};
      end else if (paddr == core_mode_pkg::OFF_RESULT_BG_LOW) begin
        next_st.rdata = st.result_bg[31:0];
      end else if (paddr == core_mode_pkg::OFF_RESULT_FG_LOW) begin
        next_st.rdata = st.result_fg[31:0];
      end else if (paddr == core_mode_pkg::OFF_RESULT_BG_MID) begin
        next_st.rdata = st.result_bg[63:32];
      end else if (paddr == core_mode_pkg::OFF_RESULT_FG_MID) begin
        next_st.rdata = st.result_fg[63:32];
      end else if (paddr == core_mode_pkg::OFF_RESULT_BG_HIGH) begin
        next_st.rdata = {16'h0, st.result_bg[79:64]};
      end else if (paddr == core_mode_pkg::OFF_RESULT_FG_HIGH) begin
        next_st.rdata = {16'h0, st.result_fg[79:64]};
      end else if (paddr == core_mode_pkg::OFF_TIMER_COUNT) begin
        next_st.rdata = st.timer;
      end else if (paddr == core_mode_pkg::OFF_IRQ_MASK) begin
        next_st.rdata = 32'(st.mask);
      end else begin
        next_st.slverr = 1'b1;
      end
    end

    // Registered control outputs for the rest of the core.
    next_st.ctrl.cache_freeze  = st.mode_second[core_mode_pkg::BIT_CACHE_FREEZE];
    next_st.ctrl.cache_disable = st.mode_second[core_mode_pkg::BIT_CACHE_DISABLE];
    next_st.ctrl.slow_loop     = st.mode_second[core_mode_pkg::BIT_SLOW_LOOP];
    next_st.ctrl.timer_run     = st.mode_second[core_mode_pkg::BIT_TIMER_RUN];
    next_st.ctrl.self_nest     = st.mode_second[core_mode_pkg::BIT_SELF_NEST_EN];
    next_st.fill_ok = cache_fill_req
                      && !st.mode_second[core_mode_pkg::BIT_CACHE_FREEZE]
                      && !st.mode_second[core_mode_pkg::BIT_CACHE_DISABLE];
    next_st.late_mode = st.mode_second[core_mode_pkg::BIT_SLOW_LOOP]
                        || !loop_early_req;
    next_st.may_latch = comb_may_latch;
    next_st.mask      = comb_mask;
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Registers the whole state on every edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops.
  assign prdata         = st.rdata;
  assign pready         = st.ready;
  assign pslverr        = st.slverr;
  assign mode_ctrl      = st.ctrl;
  assign cache_fill_ok  = st.fill_ok;
  assign loop_late_mode = st.late_mode;
  assign sys_may_latch  = st.may_latch;
  assign irq_mask       = st.mask;

endmodule // core_mode_regs

// ---- logic/result_slice_merge.sv ----
/*
  Holds the slice write merge for one 80-bit multiplier result.
  Assumes the caller supplies a one-hot slice select.
*/
`timescale 1ns/100ps
module result_slice_merge (
  input  wire logic [79:0] current,
  input  wire logic [2:0]  slice_sel,
  input  wire logic [31:0] wdata,
  output logic      [79:0] merged
);
  // ==========================================================================
  // Merge
  // ==========================================================================
  // Replaces only the selected slice and keeps every other bit.
  always_comb begin
    merged = current;
    if (slice_sel[0]) begin
      merged[31:0] = wdata;
    end else if (slice_sel[1]) begin
      merged[63:32] = wdata;
    end else if (slice_sel[2]) begin
      merged[79:64] = wdata[15:0];
    end
  end
endmodule // result_slice_merge

// ---- logic/system_irq_mask.sv ----
/*
  Holds the mask logic for the system-controller interrupt and the
  interrupts below it. Bit 0 of each vector is the system interrupt;
  higher indexes are lower priority, lower indexes higher.
  Assumes the vectors are synchronous to pclk.
*/
`timescale 1ns/100ps
module system_irq_mask #(
  parameter int N = 8
) (
  input  wire logic         self_nest,
  input  wire logic         global_en,
  input  wire logic         nesting,
  input  wire logic         sys_in_service,
  input  wire logic         higher_in_service,
  output logic              sys_may_latch,
  output logic      [N-1:0] mask
);
  // ==========================================================================
  // Mask decision
  // ==========================================================================
  // Self nesting lets a new request latch while its own routine runs.
  always_comb begin
    sys_may_latch = !sys_in_service || self_nest;
    mask = '0;
    if (higher_in_service) begin
      mask[0] = 1'b1;
    end else if (self_nest && global_en && nesting && sys_in_service) begin
      mask = {{(N-1){1'b1}}, 1'b0};
    end
  end
endmodule // system_irq_mask

// ---- pkg/core_mode_pkg.sv ----
/*
  Holds the register map, field positions, reset values and carrier
  types of the core mode and multiplier result register bank.
  Assumes a single 10 MHz APB clock domain with 32-bit data.
*/
// Function
// - Stack top exposes rounding, saturation, interrupt bits
// - Stack top exposes alternate register select bits
// - Stack top exposes swap and bit-reverse bits
// - Misaligned long access sets sticky when enabled
// - Illegal register access sets sticky when enabled
// - Freeze keeps conflict cache contents, blocks fills
// - Slow loop forces late-termination loop mode
// - Core timer runs only while enable set
// - Disable bit turns conflict cache off
// - Self-nest lets system interrupt latch again
// - Nesting in service masks lower, keeps own (code: only while self-nest and global enable are also set)
// - Higher preemption masks the system interrupt
// - Slice zero maps result bits 31:0
// - Slice one maps result bits 63:32
// - Slice two maps result bits 79:64
// - MAC writes into the result register that to_background selects
// - Swap select exchanges foreground and background
package core_mode_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [7:0] OFF_MODE_STACK_TOP = 8'h00;
  localparam logic [7:0] OFF_MODE_SECOND    = 8'h04;
  localparam logic [7:0] OFF_MODE_FIRST     = 8'h08;
  localparam logic [7:0] OFF_STICKY         = 8'h0c;
  localparam logic [7:0] OFF_RESULT_BG_LOW  = 8'h10;
  localparam logic [7:0] OFF_RESULT_FG_LOW  = 8'h14;
  localparam logic [7:0] OFF_RESULT_BG_MID  = 8'h18;
  localparam logic [7:0] OFF_RESULT_FG_MID  = 8'h1c;
  localparam logic [7:0] OFF_RESULT_BG_HIGH = 8'h20;
  localparam logic [7:0] OFF_RESULT_FG_HIGH = 8'h24;
  localparam logic [7:0] OFF_TIMER_COUNT    = 8'h28;
  localparam logic [7:0] OFF_IRQ_MASK       = 8'h2c;

  // ==========================================================================
  // Mode register field positions
  // ==========================================================================
  localparam int BIT_ROUND_TO_ZERO = 15;
  localparam int BIT_SIGN_EXTEND   = 14;
  localparam int BIT_SATURATION    = 13;
  localparam int BIT_GLOBAL_IRQ_EN = 12;
  localparam int BIT_IRQ_NESTING   = 11;
  localparam int BIT_ALT_DATA_LOW  = 10;
  localparam int BIT_ALT_DATA_HIGH = 7;
  localparam int BIT_ALT_AG2_LOW   = 6;
  localparam int BIT_ALT_AG2_HIGH  = 5;
  localparam int BIT_ALT_AG1_LOW   = 4;
  localparam int BIT_ALT_AG1_HIGH  = 3;
  localparam int BIT_RESULT_SWAP   = 2;
  localparam int BIT_BITREV_ZERO   = 1;
  localparam int BIT_BITREV_EIGHT  = 0;
  localparam logic [31:0] STACK_TOP_MASK = 32'h0000_fcff;

  localparam int BIT_UNALIGNED_EN  = 21;
  localparam int BIT_ILLEGAL_EN    = 20;
  localparam int BIT_CACHE_FREEZE  = 19;
  localparam int BIT_SLOW_LOOP     = 7;
  localparam int BIT_TIMER_RUN     = 5;
  localparam int BIT_CACHE_DISABLE = 4;
  localparam int BIT_SELF_NEST_EN  = 0;
  localparam logic [31:0] MODE_SECOND_MASK = 32'h0038_00b1;

  // Sticky status positions.
  localparam int BIT_UNALIGNED_STICKY = 0;
  localparam int BIT_ILLEGAL_STICKY   = 1;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int RESULT_W = 80;
  localparam int SYS_IRQ_W = 8;
  localparam logic [31:0] MODE_RESET   = 32'h0000_0000;
  localparam logic [79:0] RESULT_RESET = 80'h0;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic        valid;
    logic        to_background;
    logic [79:0] value;
  } mac_write_t;

  typedef struct packed {
    logic unaligned_long;
    logic illegal_reg;
  } access_event_t;

  typedef struct packed {
    logic cache_freeze;
    logic cache_disable;
    logic slow_loop;
    logic timer_run;
    logic self_nest;
  } mode_ctrl_t;

endpackage
